//--- design/fobm_offset_bank.sv
// Offset register chain: preset, parallel word and serial bit loading
`timescale 1ns/1ns
`default_nettype none
module fobm_offset_bank
  import fobm_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             load_preset,
  input  wire logic [OFS_W-1:0] preset_val,
  input  wire logic             serial_shift,
  input  wire logic             serial_bit,
  input  wire logic             par_load,
  input  wire logic [1:0]       par_idx,
  input  wire logic [OFS_W-1:0] par_val,
  output logic      [OFS_W-1:0] q1_ofs_y,
  output logic      [OFS_W-1:0] q1_ofs_x,
  output logic      [OFS_W-1:0] q2_ofs_y,
  output logic      [OFS_W-1:0] q2_ofs_x
);
  typedef struct packed {
    logic [SER_BITS-1:0] chain;
  } fobm_bank_st_t;

  fobm_bank_st_t st_reg;
  fobm_bank_st_t st_next;

  always_comb
  begin
    st_next = st_reg;
    if (load_preset)
      st_next.chain = {4{preset_val}};
    else if (serial_shift)
      // Oldest bit ends in the top of first_fifo_offset_y
      st_next.chain = {st_reg.chain[SER_BITS-2:0], serial_bit}; // RL5
    else if (par_load)
      st_next.chain[(3 - 32'(par_idx)) * OFS_W +: OFS_W] = par_val;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign q1_ofs_y = st_reg.chain[4*OFS_W-1:3*OFS_W];
  assign q1_ofs_x = st_reg.chain[3*OFS_W-1:2*OFS_W];
  assign q2_ofs_y = st_reg.chain[2*OFS_W-1:OFS_W];
  assign q2_ofs_x = st_reg.chain[OFS_W-1:0];
endmodule // fobm_offset_bank
`default_nettype wire

//--- design/fobm_porta_ctrl.sv
// Port A control: offset programming, loopback and mailbox steering
//
// Functional notes
// RL1: Select pins sampled during master reset choose preset, parallel or serial.
// RL2: Offsets load in parallel from Port A or serially as alternatives.
// RL3: Serial mode shifts the serial bit on each clock with enable low; the code stops shifting once SER_COUNT bits are in.
// RL4: Controller supplies 44, 48 or 52 serial bits; this build needs 44.
// RL5: First serial bit lands in first queue Y MSB, last in second queue X LSB.
// RL6: Loopback moves second queue output into first queue input.
// RL7: Loopback starts with loopback select low and transfer enable high; the code also needs control bit CTRL_LOOP_BIT set.
// RL8: Mailbox select high sends Port A transfers to a mailbox.
// RL9: Output shows second mailbox when select high, second queue otherwise.
// RL10: Serial pins are ignored unless serial mode was chosen at reset.
`timescale 1ns/1ns
`default_nettype none
module fobm_porta_ctrl
  import fobm_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              master_reset,
  input  wire logic              offset_sel1_serial_en,
  input  wire logic              offset_sel0_serial_bit,
  input  wire logic              offset_sel_third,
  input  wire logic              porta_transfer_enable,
  input  wire logic              porta_write,
  input  wire logic              porta_mailbox_select,
  input  wire logic              loopback_select_n,
  input  wire logic [DATA_W-1:0] porta_data_in,
  output logic      [DATA_W-1:0] porta_data_out,
  output logic                   porta_data_oe_n,
  input  wire logic [DATA_W-1:0] second_mailbox_reg,
  input  wire logic [DATA_W-1:0] second_queue_data,
  input  wire logic              second_queue_empty,
  output logic                   second_queue_read,
  input  wire logic              first_queue_full,
  output logic                   first_queue_write,
  output logic      [DATA_W-1:0] first_queue_data,
  output logic                   first_mailbox_write,
  output logic      [DATA_W-1:0] first_mailbox_data,
  output logic      [OFS_W-1:0]  first_fifo_offset_y,
  output logic      [OFS_W-1:0]  first_fifo_offset_x,
  output logic      [OFS_W-1:0]  second_fifo_offset_y,
  output logic      [OFS_W-1:0]  second_fifo_offset_x
);
  typedef struct packed {
    logic              wait_n;
    logic [31:0]       rdata;
    logic [1:0]        ctrl;
    fobm_mode_t        mode;
    logic [CNT_W-1:0]  scount;
    logic [2:0]        pidx;
    logic [DATA_W-1:0] dout;
    logic              oe_n;
    logic              q1_wr;
    logic [DATA_W-1:0] q1_data;
    logic              q2_rd;
    logic              mb_wr;
    logic [DATA_W-1:0] mb_data;
  } fobm_top_st_t;

  fobm_top_st_t st_reg;
  fobm_top_st_t st_next;

  logic             load_preset;
  logic [OFS_W-1:0] preset_val;
  logic             serial_shift;
  logic             par_load;
  logic [1:0]       par_idx;
  logic [2:0]       sel_code;
  logic             req;
  logic             loop_on;
  logic             a_wr;
  logic             a_rd;
  logic             ser_done;
  logic [31:0]      rd_mux;

  fobm_offset_bank u_bank (
    .clk          (clk),
    .srst         (srst),
    .load_preset  (load_preset),
    .preset_val   (preset_val),
    .serial_shift (serial_shift),
    .serial_bit   (offset_sel0_serial_bit),
    .par_load     (par_load),
    .par_idx      (par_idx),
    .par_val      (porta_data_in[OFS_W-1:0]),
    .q1_ofs_y     (first_fifo_offset_y),
    .q1_ofs_x     (first_fifo_offset_x),
    .q2_ofs_y     (second_fifo_offset_y),
    .q2_ofs_x     (second_fifo_offset_x)
  );

  assign sel_code = {offset_sel_third, offset_sel1_serial_en,
                     offset_sel0_serial_bit};
  assign req      = avs_read | avs_write;
  assign ser_done = (st_reg.scount == SER_COUNT);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (avs_address == REG_CTRL)
      rd_mux = {30'h0, st_reg.ctrl};
    else if (avs_address == REG_STATUS)
      rd_mux = {22'h0, st_reg.scount, ser_done, st_reg.mode};
    else if (avs_address == REG_Q1_OFS_Y)
      rd_mux = {21'h0, first_fifo_offset_y};
    else if (avs_address == REG_Q1_OFS_X)
      rd_mux = {21'h0, first_fifo_offset_x};
    else if (avs_address == REG_Q2_OFS_Y)
      rd_mux = {21'h0, second_fifo_offset_y};
    else if (avs_address == REG_Q2_OFS_X)
      rd_mux = {21'h0, second_fifo_offset_x};
  end

  always_comb
  begin
    st_next      = st_reg;
    load_preset  = 1'b0;
    preset_val   = fobm_preset(sel_code);
    serial_shift = 1'b0;
    par_load     = 1'b0;
    par_idx      = st_reg.pidx[1:0];
    st_next.q1_wr = 1'b0;
    st_next.q2_rd = 1'b0;
    st_next.mb_wr = 1'b0;

    // Bus: one wait cycle, then a single answer cycle
    st_next.wait_n = req & ~st_reg.wait_n;
    if (avs_read & ~st_reg.wait_n)
      st_next.rdata = rd_mux;
    if (avs_write & st_reg.wait_n & (avs_address == REG_CTRL))
      st_next.ctrl = avs_writedata[1:0];

    // Loopback only when software also allows it
    loop_on = ~loopback_select_n & porta_transfer_enable &
              st_reg.ctrl[CTRL_LOOP_BIT]; // RL7
    a_wr = porta_transfer_enable & porta_write & ~loop_on & ~master_reset;
    a_rd = porta_transfer_enable & ~porta_write & ~loop_on & ~master_reset;

    if (master_reset)
    begin
      st_next.mode   = fobm_decode_mode(sel_code); // RL1
      st_next.scount = '0;
      st_next.pidx   = '0;
      load_preset    = (fobm_decode_mode(sel_code) == FOBM_MODE_PRESET);
    end
    else if (st_reg.mode == FOBM_MODE_SERIAL && !offset_sel1_serial_en &&
             !ser_done) // RL10
    begin
      serial_shift   = 1'b1; // RL3
      st_next.scount = st_reg.scount + 6'h01; // RL4
    end

    // Pops are spaced out so a registered strobe never sees a stale head
    if (loop_on)
    begin
      if (!second_queue_empty && !first_queue_full && !st_reg.q2_rd)
      begin
        st_next.q2_rd   = 1'b1; // RL6
        st_next.q1_wr   = 1'b1; // RL6
        st_next.q1_data = second_queue_data; // RL6
      end
    end
    else if (a_wr)
    begin
      if (porta_mailbox_select)
      begin
        st_next.mb_wr   = 1'b1; // RL8
        st_next.mb_data = porta_data_in;
      end
      else if (st_reg.mode == FOBM_MODE_PARALLEL &&
               st_reg.pidx < PAR_WORDS)
      begin
        par_load     = 1'b1; // RL2
        st_next.pidx = st_reg.pidx + 3'h1;
      end
      else if (!first_queue_full)
      begin
        st_next.q1_wr   = 1'b1;
        st_next.q1_data = porta_data_in;
      end
    end
    else if (a_rd && !porta_mailbox_select && !second_queue_empty &&
             !st_reg.q2_rd)
      st_next.q2_rd = 1'b1; // RL8

    st_next.dout = porta_mailbox_select ? second_mailbox_reg
                                        : second_queue_data; // RL9
    st_next.oe_n = ~(a_rd & st_reg.ctrl[CTRL_OE_BIT]); // RL9
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_reg      <= '0;
      st_reg.ctrl <= CTRL_RESET;
      st_reg.mode <= FOBM_MODE_PRESET;
      st_reg.oe_n <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  assign avs_readdata        = st_reg.rdata;
  assign avs_waitrequest     = ~st_reg.wait_n;
  assign porta_data_out      = st_reg.dout;
  assign porta_data_oe_n     = st_reg.oe_n;
  assign second_queue_read   = st_reg.q2_rd;
  assign first_queue_write   = st_reg.q1_wr;
  assign first_queue_data    = st_reg.q1_data;
  assign first_mailbox_write = st_reg.mb_wr;
  assign first_mailbox_data  = st_reg.mb_data;
endmodule // fobm_porta_ctrl
`default_nettype wire

//--- shared/fobm_pkg.sv
// Constants, types and decode functions for the Port A offset/loopback block
package fobm_pkg;
  localparam int DATA_W   = 36;
  localparam int OFS_W    = 11;
  localparam int SER_BITS = 44;
  localparam int CNT_W    = 6;
  localparam int ADDR_W   = 5;

  // Avalon byte addresses
  localparam logic [ADDR_W-1:0] REG_CTRL     = 5'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 5'h04;
  localparam logic [ADDR_W-1:0] REG_Q1_OFS_Y = 5'h08;
  localparam logic [ADDR_W-1:0] REG_Q1_OFS_X = 5'h0c;
  localparam logic [ADDR_W-1:0] REG_Q2_OFS_Y = 5'h10;
  localparam logic [ADDR_W-1:0] REG_Q2_OFS_X = 5'h14;

  localparam logic [1:0] CTRL_RESET    = 2'h3;
  localparam int         CTRL_OE_BIT   = 0;
  localparam int         CTRL_LOOP_BIT = 1;
  localparam int         ST_MODE_LSB   = 0;
  localparam int         ST_DONE_BIT   = 3;
  localparam int         ST_CNT_LSB    = 4;

  localparam logic [CNT_W-1:0] SER_COUNT = 6'h2c;
  localparam logic [2:0]       PAR_WORDS = 3'h4;

  localparam logic [OFS_W-1:0] PRESET_8    = 11'h008;
  localparam logic [OFS_W-1:0] PRESET_16   = 11'h010;
  localparam logic [OFS_W-1:0] PRESET_64   = 11'h040;
  localparam logic [OFS_W-1:0] PRESET_256  = 11'h100;
  localparam logic [OFS_W-1:0] PRESET_1024 = 11'h400;

  // Select code is {offset_sel_third, sel1_serial_en, sel0_serial_bit}
  localparam logic [2:0] SEL_P8     = 3'h0;
  localparam logic [2:0] SEL_P16    = 3'h1;
  localparam logic [2:0] SEL_P64    = 3'h2;
  localparam logic [2:0] SEL_P256   = 3'h3;
  localparam logic [2:0] SEL_P1024  = 3'h4;
  localparam logic [2:0] SEL_SERIAL = 3'h6;

  typedef enum logic [2:0] {
    FOBM_MODE_PRESET   = 3'b001,
    FOBM_MODE_PARALLEL = 3'b010,
    FOBM_MODE_SERIAL   = 3'b100
  } fobm_mode_t;

  function automatic fobm_mode_t fobm_decode_mode(input logic [2:0] sel);
    if (sel <= SEL_P1024)
      return FOBM_MODE_PRESET;
    else if (sel == SEL_SERIAL)
      return FOBM_MODE_SERIAL;
    else
      return FOBM_MODE_PARALLEL;
  endfunction

  function automatic logic [OFS_W-1:0] fobm_preset(input logic [2:0] sel);
    if (sel == SEL_P8)
      return PRESET_8;
    else if (sel == SEL_P16)
      return PRESET_16;
    else if (sel == SEL_P64)
      return PRESET_64;
    else if (sel == SEL_P256)
      return PRESET_256;
    else
      return PRESET_1024;
  endfunction
endpackage

//--- sim/fobm_porta_ctrl_asserts.sv
// Port A control checker
`timescale 1ns/1ns
`default_nettype none
module fobm_chk
  import fobm_pkg::*;
(
  input wire logic              clk,
  input wire logic              srst,
  input wire logic              master_reset,
  input wire logic              offset_sel1_serial_en,
  input wire logic              offset_sel0_serial_bit,
  input wire logic              offset_sel_third,
  input wire logic              porta_transfer_enable,
  input wire logic              porta_write,
  input wire logic              porta_mailbox_select,
  input wire logic              loopback_select_n,
  input wire logic              first_queue_full,
  input wire logic              second_queue_empty,
  input wire logic [DATA_W-1:0] porta_data_in,
  input wire logic [DATA_W-1:0] second_mailbox_reg,
  input wire logic [DATA_W-1:0] second_queue_data,
  input wire logic [DATA_W-1:0] porta_data_out,
  input wire logic              second_queue_read,
  input wire logic              first_queue_write,
  input wire logic [DATA_W-1:0] first_queue_data,
  input wire logic              first_mailbox_write,
  input wire logic [DATA_W-1:0] first_mailbox_data,
  input wire logic [OFS_W-1:0]  first_fifo_offset_y
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire rq = porta_transfer_enable && !master_reset && loopback_select_n;
  wire mb = porta_mailbox_select;
  // Mode latched at master reset, so the offset hold covers the other modes
  logic ser_mode;
  always_ff @(posedge clk)
  begin
    if (srst)
      ser_mode <= 1'b0;
    else if (master_reset)
      ser_mode <= ({offset_sel_third, offset_sel1_serial_en,
                    offset_sel0_serial_bit} == SEL_SERIAL);
  end
  a_mbx_write: assert property (rq && porta_write && mb |=>
    first_mailbox_write && !first_queue_write &&
    first_mailbox_data == $past(porta_data_in)) else $error("mbx write");
  a_mail_read: assert property (rq && !porta_write && mb |=>
    porta_data_out == $past(second_mailbox_reg)) else $error("mail read");
  a_fifo_read: assert property (
    rq && !porta_write && !mb && !second_queue_empty |=>
    porta_data_out == $past(second_queue_data)) else $error("fifo read");
  a_loop_route: assert property (
    first_queue_write && second_queue_read |->
    first_queue_data == $past(second_queue_data)) else $error("loop data");
  a_pop_gap: assert property (second_queue_read |=>
    !second_queue_read) else $error("pop spacing");
  a_no_pop: assert property (
    !porta_transfer_enable || master_reset |=> !second_queue_read)
    else $error("pop without enable");
  a_full_drop: assert property (rq && porta_write && !mb &&
    first_queue_full |=> !first_queue_write) else $error("write on full");
  a_ofs_hold: assert property (
    !master_reset && !ser_mode &&
    !(porta_transfer_enable && porta_write) |=>
    $stable(first_fifo_offset_y)) else $error("offset moved");
endmodule // fobm_chk
bind fobm_porta_ctrl fobm_chk fobm_chk_i (.*);
`default_nettype wire

//--- sim/fobm_q2_model.sv
// Second queue model: head word, empty flag and pop
`timescale 1ns/1ns
`default_nettype none
module fobm_q2_model
  import fobm_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [3:0]        avail,
  input  wire logic              pop,
  output logic      [DATA_W-1:0] head,
  output logic                   empty
);
  logic [3:0] idx_reg;
  always_ff @(posedge clk)
    if (srst)
      idx_reg <= 4'h0;
    else if (pop && !empty)
      idx_reg <= idx_reg + 4'h1;
  assign empty = idx_reg >= avail;
  // Empty shows a non-word so a stale head cannot pass
  assign head = empty ? {32'h0, ~idx_reg} : {32'hc0de0000, idx_reg};
endmodule // fobm_q2_model
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the Port A control block
`timescale 1ns/1ns
`default_nettype none
module tb import fobm_pkg::*;;
  logic clk = 0, srst = 1, avs_read = 0, avs_write = 0, master_reset = 0;
  logic offset_sel1_serial_en = 1, offset_sel0_serial_bit = 0, g;
  logic offset_sel_third = 0, porta_transfer_enable = 0, porta_write = 0;
  logic porta_mailbox_select = 0, loopback_select_n = 1;
  logic first_queue_full = 0, avs_waitrequest, porta_data_oe_n;
  logic second_queue_empty, second_queue_read, first_queue_write;
  logic first_mailbox_write;
  logic [ADDR_W-1:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, q;
  logic [DATA_W-1:0] porta_data_in = '0, second_mailbox_reg = '0, d;
  logic [DATA_W-1:0] porta_data_out, second_queue_data, first_queue_data;
  logic [DATA_W-1:0] first_mailbox_data, wq[$];
  logic [OFS_W-1:0] first_fifo_offset_y, first_fifo_offset_x;
  logic [OFS_W-1:0] second_fifo_offset_y, second_fifo_offset_x;
  logic [10:0] tab[5] = '{11'h008, 11'h010, 11'h040, 11'h100, 11'h400};
  logic [3:0] avail = 0;
  logic [43:0] ex;
  wire [43:0] ofs = {first_fifo_offset_y, first_fifo_offset_x,
                     second_fifo_offset_y, second_fifo_offset_x};
  int fails = 0, samples_checked = 0, i;
  fobm_porta_ctrl fobm_porta_ctrl_i (.*);
  fobm_q2_model fobm_q2_model_i (.clk, .srst, .avail,
    .pop(second_queue_read), .head(second_queue_data),
    .empty(second_queue_empty));
  always #20 clk = ~clk;
  task automatic chk(input logic [43:0] gv, ev);
    samples_checked++;
    if (gv !== ev)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, gv, ev);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input int v);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= v;
    // No cycle count assumed; only the watchdog ends a hung access
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
  endtask
  // Returns in the one cycle in which the answer to the transfer stands
  task automatic pa(input logic w, m, input logic [DATA_W-1:0] v);
    @(posedge clk);
    porta_transfer_enable <= 1;
    porta_write <= w;
    porta_mailbox_select <= m;
    porta_data_in <= v;
    @(posedge clk);
    porta_transfer_enable <= 0;
    @(negedge clk);
  endtask
  task automatic mrst(input logic [2:0] s);
    @(posedge clk);
    master_reset <= 1;
    {offset_sel_third, offset_sel1_serial_en, offset_sel0_serial_bit} <= s;
    repeat (3) @(posedge clk);
    master_reset <= 0;
    offset_sel1_serial_en <= 1;
    @(negedge clk);
  endtask
  always @(negedge clk)
    if (first_queue_write === 1'b1)
      chk(first_queue_data, wq.size() ? wq.pop_front() : 'x);
  initial
  begin
    void'($urandom(23502));
    repeat (8) @(posedge clk);
    srst <= 0;
    bus(0, REG_CTRL, 0);
    chk(q, 3);
    bus(0, 5'h1c, 0);
    chk(q, 0);
    for (i = 0; i < 5; i++)
    begin
      mrst(i[2:0]);
      chk(first_fifo_offset_y, tab[i]);
      chk(second_fifo_offset_x, tab[i]);
    end
    mrst(SEL_SERIAL);
    ex = 44'({$urandom, $urandom});
    i = 0;
    // Gaps with enable high carry a wrong bit; three extra bits follow
    while (i < 47)
    begin
      @(posedge clk);
      g = ($urandom % 3 == 0) && i < 44;
      offset_sel1_serial_en <= g;
      offset_sel0_serial_bit <= (i < 44) ? ex[43 - i] ^ g : 1'($urandom);
      i += !g;
    end
    @(posedge clk);
    offset_sel1_serial_en <= 1;
    @(negedge clk);
    chk(ofs, ex);
    bus(0, REG_STATUS, 0);
    chk(q, SER_BITS * 16 + 12);
    mrst(3'h5);
    ex = 44'({$urandom, $urandom});
    for (i = 0; i < 4; i++)
      pa(1, 0, 36'(ex[43 - 11 * i -: 11]));
    repeat (4)
    begin
      @(posedge clk);
      offset_sel1_serial_en <= 0;
      offset_sel0_serial_bit <= 1'($urandom);
    end
    @(posedge clk);
    offset_sel1_serial_en <= 1;
    @(negedge clk);
    chk(ofs, ex);
    wq.push_back(36'h5a5a5a5a5);
    pa(1, 0, 36'h5a5a5a5a5);
    d = 36'({$urandom, $urandom});
    @(posedge clk);
    first_queue_full <= 1;
    second_mailbox_reg <= d;
    pa(1, 0, ~d);
    pa(1, 1, d);
    chk(first_mailbox_data, d);
    pa(0, 1, 0);
    chk(porta_data_out, d);
    chk(porta_data_oe_n, 0);
    @(posedge clk);
    first_queue_full <= 0;
    avail <= 1;
    pa(0, 0, 0);
    chk(porta_data_out, {32'hc0de0000, 4'h0});
    chk(second_queue_read, 1);
    for (i = 1; i < 4; i++)
      wq.push_back({32'hc0de0000, i[3:0]});
    @(posedge clk);
    avail <= 4;
    loopback_select_n <= 0;
    porta_transfer_enable <= 1;
    repeat (12) @(posedge clk);
    loopback_select_n <= 1;
    porta_transfer_enable <= 0;
    bus(1, REG_CTRL, 1);
    bus(0, REG_CTRL, 0);
    chk(q, 1);
    chk(wq.size(), 0);
    summarize();
  end
  initial
  begin
    #100000;
    fails++;
    summarize();
  end
endmodule // tb
`default_nettype wire
